// *** sds_pkg.sv ***
// Package for the slice decode scheduler: register map, fields, reset values.
// Assumes a 32-bit AXI4-Lite slave and one pixel time per clock.
`default_nettype none
package sds_pkg;
  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam int          AW      = 6;
  localparam logic [5:0]  A_CTRL  = 6'h00;
  localparam logic [5:0]  A_LAG   = 6'h04;
  localparam logic [5:0]  A_SW    = 6'h08;
  localparam logic [5:0]  A_HBL   = 6'h0C;
  localparam logic [5:0]  A_BPP   = 6'h10;
  localparam logic [5:0]  A_RBS   = 6'h14;
  localparam logic [5:0]  A_XDLY  = 6'h18;
  localparam logic [5:0]  A_STAT  = 6'h1C;
  localparam logic [5:0]  A_XBUF  = 6'h20;
  localparam logic [5:0]  A_PEAK  = 6'h24;
  // ----------------------------------------------------------------
  // Fields and masks
  // ----------------------------------------------------------------
  localparam int          CTRL_EN  = 0;
  localparam int          CTRL_BLK = 1;
  localparam int          CTRL_NSL = 2;
  localparam int          STAT_OVF = 0;
  localparam int          STAT_UDF = 1;
  localparam int          STAT_BSY = 8;
  localparam logic [31:0] M_CTRL   = 32'h0000_000F;
  localparam logic [31:0] M_16     = 32'h0000_FFFF;
  localparam logic [31:0] M_8      = 32'h0000_00FF;
  localparam logic [31:0] M_24     = 32'h00FF_FFFF;
  // ----------------------------------------------------------------
  // Reset values, bus response codes and slice phases
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_LAG  = 32'h0000_0100;
  localparam logic [31:0] RST_SW   = 32'h0000_0200;
  localparam logic [31:0] RST_HBL  = 32'h0000_0040;
  localparam logic [31:0] RST_BPP  = 32'h0000_0008;
  localparam logic [31:0] RST_RBS  = 32'h0000_1800;
  localparam logic [31:0] RST_XDLY = 32'h0000_0000;
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_ERR = 2'h2;
  typedef enum logic [1:0] {SL_IDLE, SL_WAIT, SL_DEC} sds_phase_t;
endpackage : sds_pkg
`default_nettype wire

// *** sds_slice_sched.sv ***
// Slice decode scheduler with compressed-data FIFO and AXI4-Lite registers.
// Assumes same-clock stream source and decoder core; one pixel time per aclk.
// Contract
// - Blanking and slice count never change the algorithm; only timing/buffers adapt.
// - No blanking, one slice: start decode one startup lag after first bit.
// - Blanking, one slice: start no earlier than lag plus blanking after first bit.
// - Extra storage of blanking time times bits per pixel is provided.
// - Extra start delay is allowed and enlarges the buffer to match.
// - Each slice is scheduled from its own data arrival.
// - Idealized: part one starts a lag after arrival, part two next segment.
// - Slices decode in parallel at pixel rate divided by slice count.
// - Two slices: part two starts at second segment, part one just before.
// - No pixel is decoded earlier than the idealized schedule allows.
// - Two slices: extra buffer bound is slice width minus lag, times bpp.
// - Tighter bound: segment size times bpp beyond rate buffer size.
// - Four slices: slice line decode spans four segment times.
// - Four slices, lag over a segment: part two starts at third segment.
// - Four slices, no blanking: extra buffer is added delay times bpp.
// - Four slices, blanking: extra buffer is segment minus leftover lag, times bpp.
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Shift-register FIFO, head always in word 0
// ----------------------------------------------------------------
module sds_fifo #(
  parameter int W = 34,
  parameter int D = 4
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int CNTW = $clog2(D + 1);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [CNTW-1:0]     cnt;
    logic                rdy;
    logic                vld;
  } sds_fifo_st_t;
  sds_fifo_st_t q, n;
  logic            push;
  logic            pop;
  logic [CNTW-1:0] c;

  always_comb begin
    n    = q;
    push = in_valid && q.rdy;
    pop  = q.vld && out_ready;
    c    = q.cnt;
    if (pop) begin
      for (int i = 0; i < D - 1; i++) begin
        n.mem[i] = q.mem[i+1];
      end
      c = q.cnt - CNTW'(1);
    end
    if (push) begin
      n.mem[c] = in_data;
      c = c + CNTW'(1);
    end
    n.cnt = c;
    // Flags registered so the ports come straight from flops
    n.rdy = (c != CNTW'(D));
    n.vld = (c != CNTW'(0));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign in_ready  = q.rdy;
  assign out_valid = q.vld;
  assign out_data  = q.mem[0];
endmodule : sds_fifo

// ----------------------------------------------------------------
// Top: scheduler, fullness tracking, register slave
// ----------------------------------------------------------------
module sds_slice_sched #(
  parameter int NS = 4,
  parameter int DW = 32,
  parameter int FD = 4,
  parameter int CW = 20,
  parameter int FW = 24
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [sds_pkg::AW-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [sds_pkg::AW-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   in_valid,
  output logic                        in_ready,
  input  wire logic [DW-1:0]          in_data,
  input  wire logic [1:0]             in_slice,
  input  wire logic                   in_first,
  output logic                        dec_valid,
  input  wire logic                   dec_ready,
  output logic [DW+1:0]               dec_data,
  output logic [NS-1:0]               dec_start,
  output logic [NS-1:0]               dec_pix
);
  typedef struct packed {
    logic                                awr;
    logic                                bv;
    logic [1:0]                          br;
    logic                                arr;
    logic                                rv;
    logic [1:0]                          rr;
    logic [31:0]                         rd;
    logic [31:0]                         ctrl;
    logic [31:0]                         lag;
    logic [31:0]                         sw;
    logic [31:0]                         hbl;
    logic [31:0]                         bpp;
    logic [31:0]                         rbs;
    logic [31:0]                         xdly;
    logic                                ovf;
    logic                                udf;
    logic [31:0]                         xbuf;
    logic [31:0]                         peak;
    logic [NS-1:0][1:0]                  ph;
    logic [NS-1:0][CW-1:0]               tmr;
    logic [NS-1:0][15:0]                 pix;
    logic [NS-1:0][1:0]                  pace;
    logic [NS-1:0][FW-1:0]               full;
    logic [NS-1:0]                       start;
    logic [NS-1:0]                       strb;
  } sds_st_t;

  sds_st_t     q, n;
  logic        fifo_rdy;
  logic        en;
  logic        blk;
  logic [1:0]  nsl;
  logic [1:0]  pmax;
  logic [15:0] lg;
  logic [15:0] cw;
  logic [15:0] rm;
  logic [CW-1:0] core;
  logic [CW-1:0] spt;
  logic [31:0] base;
  logic [31:0] lim;
  logic [31:0] pk;
  logic [FW-1:0] nf;
  logic        hit;
  logic        ovf_set;
  logic        udf_set;
  logic [NS-1:0] bsy;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) r[8*b +: 8] = d[8*b +: 8];
    end
    return r;
  endfunction : merge

  // ----------------------------------------------------------------
  // Compressed data path
  // ----------------------------------------------------------------
  // Words pass unchanged
  // Slice tag travels with the word so the core can route it
  sds_fifo #(.W(DW + 2), .D(FD)) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (in_valid),
    .in_ready  (fifo_rdy),
    .in_data   ({in_slice, in_data}),
    .out_valid (dec_valid),
    .out_ready (dec_ready),
    .out_data  (dec_data)
  );

  always_comb begin
    n    = q;
    ovf_set = 1'b0;
    udf_set = 1'b0;
    en   = q.ctrl[sds_pkg::CTRL_EN];
    blk  = q.ctrl[sds_pkg::CTRL_BLK];
    nsl  = q.ctrl[sds_pkg::CTRL_NSL +: 2];
    pmax = (nsl == 2'h0) ? 2'h0 : (nsl == 2'h1) ? 2'h1 : 2'h3;
    lg   = q.lag[15:0];
    cw   = q.sw[15:0];
    rm   = (lg > cw) ? lg - cw : 16'h0;
    // Lag scaled by slice count
    // Part one ends where the next segment begins, so start = N * lag
    core = CW'(lg) << nsl;
    spt  = core + ((blk && nsl == 2'h0) ? CW'(q.hbl[15:0]) : CW'(0))
         + CW'(q.xdly[15:0]);
    base = 32'h0;
    case (nsl)
      2'h0: begin
        if (blk) base = (q.hbl & sds_pkg::M_16) * (q.bpp & sds_pkg::M_8);
      end
      2'h1: begin
        base = {16'h0, (cw > lg) ? cw - lg : 16'h0} * (q.bpp & sds_pkg::M_8);
      end
      default: begin
        if (blk) begin
          base = {16'h0, (cw > rm) ? cw - rm : 16'h0} * (q.bpp & sds_pkg::M_8);
        end else begin
          base = {{(32 - CW){1'b0}}, core - CW'(lg)} * (q.bpp & sds_pkg::M_8);
        end
      end
    endcase
    // Buffer grows with the added delay
    n.xbuf = base + (q.xdly & sds_pkg::M_16) * (q.bpp & sds_pkg::M_8);
    pk     = ({16'h0, cw} << ((nsl == 2'h2) ? 1 : 0)) * (q.bpp & sds_pkg::M_8);
    n.peak = (pk > (q.rbs & sds_pkg::M_24)) ? pk - (q.rbs & sds_pkg::M_24) : 32'h0;
    lim    = (q.rbs & sds_pkg::M_24) + q.xbuf;
    // ----------------------------------------------------------------
    // Per-slice schedule
    // ----------------------------------------------------------------
    for (int s = 0; s < NS; s++) begin
      hit        = in_valid && fifo_rdy && (in_slice == 2'(s));
      n.start[s] = 1'b0;
      n.strb[s]  = 1'b0;
      case (sds_pkg::sds_phase_t'(q.ph[s]))
        sds_pkg::SL_IDLE: begin
          if (en && hit && in_first) begin
            n.ph[s]  = sds_pkg::SL_WAIT;
            n.tmr[s] = CW'(0);
          end
        end
        sds_pkg::SL_WAIT: begin
          n.tmr[s] = q.tmr[s] + CW'(1);
          // Start once the start point is reached
          // Start sized so part two meets segment two
          // Same formula lands part two on segment three
          if (q.tmr[s] == spt) begin
            n.ph[s]    = sds_pkg::SL_DEC;
            n.start[s] = 1'b1;
            n.pix[s]   = 16'h0;
            n.pace[s]  = 2'h0;
          end
        end
        sds_pkg::SL_DEC: begin
          n.pace[s] = q.pace[s] + 2'h1;
          if (q.pace[s] == pmax) begin
            n.pace[s] = 2'h0;
            n.strb[s] = 1'b1;
            n.pix[s]  = q.pix[s] + 16'h1;
            if (q.pix[s] == cw - 16'h1) n.ph[s] = sds_pkg::SL_IDLE;
          end
        end
        default: n.ph[s] = sds_pkg::SL_IDLE;
      endcase
      if (!en) n.ph[s] = sds_pkg::SL_IDLE;
      // Fullness in on arrival, out on decode
      nf = q.full[s] + (hit ? FW'(DW) : FW'(0));
      if (n.strb[s]) begin
        if (nf < FW'(q.bpp[7:0])) begin
          n.udf   = 1'b1;
          udf_set = 1'b1;
          nf      = FW'(0);
        end else begin
          nf = nf - FW'(q.bpp[7:0]);
        end
      end
      if ({{(32 - FW){1'b0}}, nf} > lim) begin
        n.ovf   = 1'b1;
        ovf_set = 1'b1;
      end
      n.full[s] = nf;
      bsy[s]    = (q.ph[s] != 2'(sds_pkg::SL_IDLE));
    end
    // ----------------------------------------------------------------
    // AXI4-Lite write
    // ----------------------------------------------------------------
    if (q.bv && s_axi_bready) n.bv = 1'b0;
    if (q.awr) begin
      n.awr = 1'b0;
      n.bv  = 1'b1;
      n.br  = sds_pkg::RESP_OK;
      case (s_axi_awaddr)
        sds_pkg::A_CTRL: n.ctrl = merge(q.ctrl, s_axi_wdata, s_axi_wstrb) & sds_pkg::M_CTRL;
        sds_pkg::A_LAG:  n.lag  = merge(q.lag, s_axi_wdata, s_axi_wstrb) & sds_pkg::M_16;
        sds_pkg::A_SW:   n.sw   = merge(q.sw, s_axi_wdata, s_axi_wstrb) & sds_pkg::M_16;
        sds_pkg::A_HBL:  n.hbl  = merge(q.hbl, s_axi_wdata, s_axi_wstrb) & sds_pkg::M_16;
        sds_pkg::A_BPP:  n.bpp  = merge(q.bpp, s_axi_wdata, s_axi_wstrb) & sds_pkg::M_8;
        sds_pkg::A_RBS:  n.rbs  = merge(q.rbs, s_axi_wdata, s_axi_wstrb) & sds_pkg::M_24;
        sds_pkg::A_XDLY: n.xdly = merge(q.xdly, s_axi_wdata, s_axi_wstrb) & sds_pkg::M_16;
        sds_pkg::A_STAT: begin
          // Set wins over a clear in the same cycle, even when already set
          if (s_axi_wstrb[0] && s_axi_wdata[sds_pkg::STAT_OVF] && !ovf_set) n.ovf = 1'b0;
          if (s_axi_wstrb[0] && s_axi_wdata[sds_pkg::STAT_UDF] && !udf_set) n.udf = 1'b0;
        end
        sds_pkg::A_XBUF, sds_pkg::A_PEAK: ;
        default: n.br = sds_pkg::RESP_ERR;
      endcase
    end else if (!q.bv && s_axi_awvalid && s_axi_wvalid) begin
      n.awr = 1'b1;
    end
    // ----------------------------------------------------------------
    // AXI4-Lite read
    // ----------------------------------------------------------------
    if (q.rv && s_axi_rready) n.rv = 1'b0;
    if (q.arr) begin
      n.arr = 1'b0;
      n.rv  = 1'b1;
      n.rr  = sds_pkg::RESP_OK;
      case (s_axi_araddr)
        sds_pkg::A_CTRL: n.rd = q.ctrl;
        sds_pkg::A_LAG:  n.rd = q.lag;
        sds_pkg::A_SW:   n.rd = q.sw;
        sds_pkg::A_HBL:  n.rd = q.hbl;
        sds_pkg::A_BPP:  n.rd = q.bpp;
        sds_pkg::A_RBS:  n.rd = q.rbs;
        sds_pkg::A_XDLY: n.rd = q.xdly;
        sds_pkg::A_STAT: begin
          n.rd                                = 32'h0;
          n.rd[sds_pkg::STAT_OVF]             = q.ovf;
          n.rd[sds_pkg::STAT_UDF]             = q.udf;
          n.rd[sds_pkg::STAT_BSY +: NS]       = bsy;
        end
        sds_pkg::A_XBUF: n.rd = q.xbuf;
        sds_pkg::A_PEAK: n.rd = q.peak;
        default: begin
          n.rd = 32'h0;
          n.rr = sds_pkg::RESP_ERR;
        end
      endcase
    end else if (!q.rv && s_axi_arvalid) begin
      n.arr = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q      <= '0;
      q.ctrl <= sds_pkg::RST_CTRL;
      q.lag  <= sds_pkg::RST_LAG;
      q.sw   <= sds_pkg::RST_SW;
      q.hbl  <= sds_pkg::RST_HBL;
      q.bpp  <= sds_pkg::RST_BPP;
      q.rbs  <= sds_pkg::RST_RBS;
      q.xdly <= sds_pkg::RST_XDLY;
    end else begin
      q <= n;
    end
  end

  assign s_axi_awready = q.awr;
  assign s_axi_wready  = q.awr;
  assign s_axi_bvalid  = q.bv;
  assign s_axi_bresp   = q.br;
  assign s_axi_arready = q.arr;
  assign s_axi_rvalid  = q.rv;
  assign s_axi_rresp   = q.rr;
  assign s_axi_rdata   = q.rd;
  assign in_ready      = fifo_rdy;
  assign dec_start     = q.start;
  assign dec_pix       = q.strb;

  // ----------------------------------------------------------------
  // Assertions (slice 0 watched; slices share the logic)
  // ----------------------------------------------------------------
  logic [CW:0] since_q;
  logic [CW:0] dur_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      since_q <= '0;
      dur_q   <= '0;
    end else begin
      since_q <= (q.ph[0] == 2'(sds_pkg::SL_IDLE)) ? '0 : since_q + 1'b1;
      dur_q   <= (q.ph[0] == 2'(sds_pkg::SL_DEC)) ? dur_q + 1'b1 : '0;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  lag_start_a : assert property (
    dec_start[0] && nsl == 2'h0 && !blk |-> since_q == lg + q.xdly[15:0] + 1)
    else $error("single slice start not at lag");
  blank_start_a : assert property (
    dec_start[0] && nsl == 2'h0 && blk |-> since_q == lg + q.hbl[15:0] + q.xdly[15:0] + 1)
    else $error("blanking start not at lag plus blanking");
  par_start_a : assert property (
    dec_start[0] && nsl != 2'h0 |-> since_q == (lg << nsl) + q.xdly[15:0] + 1)
    else $error("parallel start misplaced");
  no_early_a : assert property (
    dec_start[0] |-> since_q > lg)
    else $error("decode earlier than idealized");
  half_rate_a : assert property (
    dec_pix[0] && nsl == 2'h1 |=> !dec_pix[0] ##1 (dec_pix[0] || q.ph[0] != 2'(sds_pkg::SL_DEC)))
    else $error("two slice pace wrong");
  line_span_a : assert property (
    q.ph[0] == 2'(sds_pkg::SL_DEC) ##1 q.ph[0] == 2'(sds_pkg::SL_IDLE) && en
      |-> $past(dur_q) == ({1'b0, 4'h0, cw} << nsl) - 1)
    else $error("slice line decode span wrong");
  ovf_flag_a : assert property (
    ({8'h0, q.full[0]} > lim) |=> q.ovf)
    else $error("overflow not flagged");
  blank_buf_a : assert property (
    $stable(q.ctrl) && $stable(q.hbl) && $stable(q.bpp) && $stable(q.xdly)
      && nsl == 2'h0 && blk && q.xdly == 32'h0 |=> q.xbuf == q.hbl * q.bpp)
    else $error("blanking buffer size wrong");
  axi_resp_a : assert property (
    s_axi_awready |=> s_axi_bvalid)
    else $error("write response missing");

  one_slice_c   : cover property (dec_start[0] && nsl == 2'h0 && blk);
  two_slice_c   : cover property (dec_start[0] && nsl == 2'h1);
  four_slice_c  : cover property (dec_start[0] && nsl == 2'h2 && lg > cw);
  fifo_full_c   : cover property (!in_ready ##1 in_ready);
endmodule : sds_slice_sched
`default_nettype wire

// *** sds_src.sv ***
// Transport model that feeds compressed words to the scheduler input.
// Assumes the scheduler's clock; the bench calls put once per word, gap at least 1.
`timescale 1ns/1ps
`default_nettype none
module sds_src (
  input  wire logic   aclk,
  input  wire logic   in_ready,
  output logic        in_valid,
  output logic [31:0] in_data,
  output logic [1:0]  in_slice,
  output logic        in_first
);
  initial begin
    in_valid = 1'b0;
    in_data  = 32'h0000_0000;
    in_slice = 2'h0;
    in_first = 1'b0;
  end
  // ----------------------------------------------------------------
  // Word delivery
  // ----------------------------------------------------------------
  // silent gap, words unchanged
  task automatic put(input logic [1:0] s, input logic f, input logic [31:0] d, input int gap, output bit ok);
    int n;
    repeat (gap) @(posedge aclk);
    in_valid <= 1'b1;
    in_data  <= d;
    in_slice <= s;
    in_first <= f;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!in_ready && n < 200);
    ok = in_ready;
    // Released lines show junk so a stale word cannot pass
    in_valid <= 1'b0;
    in_data  <= ~d;
    in_slice <= ~s;
    in_first <= ~f;
  endtask : put
endmodule : sds_src
`default_nettype wire

// *** sds_slice_sched_tb.sv ***
// Bench for the slice decode scheduler: registers, start timing, pacing, status, FIFO.
// Assumes sds_pkg, sds_slice_sched and the sds_src transport model.
`timescale 1ns/1ps
`default_nettype none
module sds_slice_sched_tb;
  logic [sds_pkg::AW-1:0] awaddr = 6'h00;
  logic [sds_pkg::AW-1:0] araddr = 6'h00;
  logic [31:0]            wdata  = 32'h0000_0000;
  logic [31:0]            rnd    = 32'h0001_49D8;
  logic [31:0]            rdata, in_data;
  logic [33:0]            dec_data;
  logic [3:0]             wstrb  = 4'hF;
  logic [3:0]             dec_start, dec_pix;
  logic [1:0]             bresp, rresp, in_slice;
  logic                   aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic                   arvalid = 1'b0, rready = 1'b0, dec_ready = 1'b0, hold = 1'b0;
  logic                   awready, wready, bvalid, arready, rvalid, in_valid, in_ready, in_first, dec_valid;
  logic [65:0]            e;
  logic [65:0]            rq[$];
  logic [33:0]            dq[$];
  logic [1:0]             bq[$];
  int                     checks = 0, n_fail = 0, cyc = 0, t0 = 0, ts = 0, tl = 0, npix = 0;
  logic [5:0]  ad [8] = '{sds_pkg::A_CTRL, sds_pkg::A_LAG, sds_pkg::A_SW, sds_pkg::A_HBL,
                          sds_pkg::A_BPP, sds_pkg::A_RBS, sds_pkg::A_XDLY, sds_pkg::A_STAT};
  logic [31:0] rv [8] = '{sds_pkg::RST_CTRL, sds_pkg::RST_LAG, sds_pkg::RST_SW, sds_pkg::RST_HBL,
                          sds_pkg::RST_BPP, sds_pkg::RST_RBS, sds_pkg::RST_XDLY, 32'h0000_0000};

  sds_slice_sched sds_slice_sched_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .in_valid(in_valid), .in_ready(in_ready),
    .in_data(in_data), .in_slice(in_slice), .in_first(in_first), .dec_valid(dec_valid),
    .dec_ready(dec_ready), .dec_data(dec_data), .dec_start(dec_start), .dec_pix(dec_pix));
  sds_src sds_src_inst (.aclk(aclk), .in_ready(in_ready), .in_valid(in_valid), .in_data(in_data),
    .in_slice(in_slice), .in_first(in_first));

  // ----------------------------------------------------------------
  // Clock, decoder-side stalls, result monitor
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr

  task automatic results();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  task automatic bad();
    n_fail++;
    results();
  endtask : bad

  task automatic chk(input logic [65:0] g, input logic [65:0] x);
    checks++;
    if (g !== x) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask : chk

  always #20 aclk = ~aclk;
  always @(posedge aclk) begin
    rnd       <= lfsr(rnd);
    dec_ready <= !hold && (rnd[0] || rnd[1]);
  end

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (in_valid && in_ready && in_first && in_slice == 2'h0) t0 <= cyc;
    if (dec_start[0]) begin
      ts   <= cyc;
      npix <= 0;
    end
    if (dec_pix[0]) begin
      npix <= npix + 1;
      tl   <= cyc;
    end
    if (rvalid && rready) begin
      e = rq.pop_front();
      chk(66'({rresp, rdata & e[63:32]}), 66'({e[65:64], e[31:0] & e[63:32]}));
    end
    if (bvalid && bready) chk(66'(bresp), 66'(bq.pop_front()));
    if (dec_valid && dec_ready) chk(66'(dec_data), 66'(dq.pop_front()));
    if (dec_start[3:1] != 3'h0 || dec_pix[3:1] != 3'h0) chk(66'({dec_start[3:1], dec_pix[3:1]}), 66'h0);
  end

  // ----------------------------------------------------------------
  // Bus, stream and scenario tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [sds_pkg::AW-1:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF,
                    input logic [1:0] r = sds_pkg::RESP_OK);
    int n;
    bq.push_back(r);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 100);
    bready <= 1'b0;
    if (!bvalid) bad();
  endtask : wr

  task automatic rd(input logic [sds_pkg::AW-1:0] a, input logic [31:0] x, input logic [31:0] m = 32'hFFFF_FFFF,
                    input logic [1:0] r = sds_pkg::RESP_OK);
    int n;
    rq.push_back({r, m, x});
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 100);
    rready <= 1'b0;
    if (!rvalid) bad();
  endtask : rd

  task automatic send(input logic [1:0] s, input logic f, input int gap);
    logic [31:0] d;
    bit          ok;
    d = rnd;
    dq.push_back({s, d});
    sds_src_inst.put(s, f, d, gap, ok);
    if (!ok) bad();
  endtask : send

  task automatic settle();
    int n;
    n = 0;
    while (dq.size() != 0 && n < 300) begin
      @(posedge aclk);
      n++;
    end
    if (n == 300) bad();
  endtask : settle

  // One slice-0 line of SW=4 pixels; start delay and pace from the settings
  task automatic run(input int nsl, blk, lag, hbl, xd, xb, xm);
    int sp, nn, n;
    sp = (lag << nsl) + ((blk == 1 && nsl == 0) ? hbl : 0) + xd;
    nn = 1 << nsl;
    wr(sds_pkg::A_CTRL, 32'h0000_0000);
    wr(sds_pkg::A_LAG, 32'(lag));
    wr(sds_pkg::A_HBL, 32'(hbl));
    wr(sds_pkg::A_XDLY, 32'(xd));
    wr(sds_pkg::A_CTRL, 32'((nsl << 2) | (blk << 1) | 1));
    rd(sds_pkg::A_XBUF, 32'(xb), 32'(xm));
    send(2'h0, 1'b1, 1);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!(ts > t0 && npix == 4) && n < 400);
    chk(66'(ts - t0), 66'(sp + 2));
    chk(66'(tl - ts), 66'(4 * nn));
    if (n == 400) bad();
  endtask : run

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (ad[i]) rd(ad[i], rv[i]);
    rd(6'h28, 32'h0000_0000, 32'hFFFF_FFFF, sds_pkg::RESP_ERR);
    wr(6'h28, 32'h0000_0000, 4'hF, sds_pkg::RESP_ERR);
    wr(sds_pkg::A_LAG, 32'hFFFF_FFFF, 4'h1);
    rd(sds_pkg::A_LAG, 32'h0000_01FF);
    wr(sds_pkg::A_SW, 32'h0000_0004);
    run(0, 0, 2, 3, 0, 0, 32'hFFFF_FFFF);
    run(0, 1, 2, 3, 0, 24, 32'hFFFF_FFFF);
    run(0, 0, 2, 3, 2, 16, 32'hFFFF_FFFF);
    run(1, 0, 3, 3, 0, 8, 32'hFFFF_FFFF);
    run(2, 1, 5, 3, 1, 32, 32'hFFFF_FFFF);
    run(2, 0, 2, 3, 0, 48, 32'hFFFF_FFFF);
    wr(sds_pkg::A_STAT, 32'h0000_0003);
    wr(sds_pkg::A_BPP, 32'h0000_0010);
    run(0, 0, 2, 3, 0, 0, 32'hFFFF_FFFF);
    rd(sds_pkg::A_STAT, 32'h0000_0002, 32'h0000_0003);
    wr(sds_pkg::A_STAT, 32'h0000_0003);
    rd(sds_pkg::A_STAT, 32'h0000_0000, 32'h0000_0003);
    wr(sds_pkg::A_BPP, 32'h0000_0008);
    wr(sds_pkg::A_RBS, 32'h0000_0010);
    run(0, 0, 2, 3, 0, 0, 32'hFFFF_FFFF);
    rd(sds_pkg::A_STAT, 32'h0000_0001, 32'h0000_0003);
    rd(sds_pkg::A_PEAK, 32'h0000_0010);
    wr(sds_pkg::A_CTRL, 32'h0000_0000);
    settle();
    hold <= 1'b1;
    repeat (2) @(posedge aclk);
    for (int i = 0; i < 4; i++) send(2'(i), 1'b0, 1);
    @(posedge aclk);
    chk(66'(in_ready), 66'h0);
    hold <= 1'b0;
    settle();
    @(posedge aclk);
    chk(66'(in_ready), 66'h1);
    results();
  end
endmodule : sds_slice_sched_tb
`default_nettype wire
